// [dv/smr_ctrl_model.sv]
// Controller model issuing mode register reads and writes.
`timescale 1ns/1ns
module smr_ctrl_model
  import smr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic [7:0] rd_data_ff,
  output smr_cmd_t cmd
);
  initial cmd = '0;
  // One command, held from just after an edge to just after the sampling edge.
  task automatic issue(input logic rd, input logic [7:0] idx, input logic [7:0] op,
    output logic [7:0] q);
    q = 8'h00;
    if (!rd && idx == SMR_IDX_BURST_WR && op[2:0] != SMR_BL_FOUR)
      op[4] = 1'b0;
    if (rd || !(idx > 8'h3F || (idx > 8'h0A && idx < 8'h10)
      || (idx > 8'h11 && idx < 8'h3F && idx != 8'h20 && idx != 8'h28)))
    begin
      @(posedge clk_sys);
      #1;
      cmd = {rd, !rd, idx, op & ((idx == 8'h02 || idx == 8'h03) ? 8'h0F : 8'hFF)};
      @(posedge clk_sys);
      #1;
      q = rd_data_ff;
      cmd = '0;
    end
  endtask
endmodule // smr_ctrl_model

// [dv/smr_mode_regs_sva.sv]
// Port checker for the mode register file.
`timescale 1ns/1ns
module smr_mode_regs_sva
  import smr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire smr_cmd_t cmd,
  input wire logic [7:0] refresh_status,
  input wire logic [7:0] rd_data_ff,
  input wire logic rd_valid_ff,
  input wire logic rd_strobe_ff,
  input wire smr_burst_t burst_cfg_ff,
  input wire logic [7:0] latency_cfg_ff,
  input wire logic zq_busy_ff,
  input wire logic use_factory_trim_ff,
  input wire logic auto_init_busy_flag_ff
);
  // One clock domain, so clock and reset are given once for every check.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  a_read_answer:
    assert property (cmd.rd |=> rd_valid_ff && rd_strobe_ff != $past(rd_strobe_ff))
    else $error("read not answered with valid and strobe");
  a_info_layout:
    assert property (cmd.rd && cmd.register_index == SMR_IDX_DEV_INFO |=> rd_data_ff[7:5] == 3'h0
      && rd_data_ff[2:1] == 2'h0 && rd_data_ff[0] == $past(auto_init_busy_flag_ff))
    else $error("device info layout wrong");
  a_refresh_read:
    assert property (cmd.rd && cmd.register_index == SMR_IDX_REFRESH
      |=> rd_data_ff == ($past(refresh_status) & SMR_REFRESH_MASK))
    else $error("refresh status read wrong");
  a_soft_reset:
    assert property (cmd.wr && cmd.register_index == SMR_IDX_SOFT_RST
      |=> auto_init_busy_flag_ff && burst_cfg_ff == SMR_BURST_WR_RST)
    else $error("soft reset not taken");
  a_ro_write_still:
    assert property (cmd.wr && cmd.register_index == SMR_IDX_DEV_INFO
      |=> $stable(burst_cfg_ff) && $stable(latency_cfg_ff))
    else $error("read-only write changed state");
  a_burst_load:
    assert property (cmd.wr && cmd.register_index == SMR_IDX_BURST_WR && !auto_init_busy_flag_ff
      |=> burst_cfg_ff[7:5] == $past(cmd.operand_bits[7:5])
      && burst_cfg_ff[3:0] == $past(cmd.operand_bits[3:0])
      && burst_cfg_ff[4] == ($past(cmd.operand_bits[4]) && burst_cfg_ff[2:0] == SMR_BL_FOUR))
    else $error("burst register load wrong");
  a_zq_start:
    assert property (cmd.wr && cmd.register_index == SMR_IDX_ZQ_CAL && !auto_init_busy_flag_ff
      && !zq_busy_ff && !use_factory_trim_ff |=> zq_busy_ff)
    else $error("calibration did not start");
  a_trim_ignore:
    assert property (cmd.wr && cmd.register_index == SMR_IDX_ZQ_CAL && use_factory_trim_ff
      && !zq_busy_ff |=> !zq_busy_ff)
    else $error("calibration ran on factory trim");
endmodule // smr_mode_regs_sva
bind smr_mode_regs smr_mode_regs_sva u_smr_mode_regs_sva (.clk_sys, .reset, .cmd,
  .refresh_status, .rd_data_ff, .rd_valid_ff, .rd_strobe_ff, .burst_cfg_ff, .latency_cfg_ff,
  .zq_busy_ff, .use_factory_trim_ff, .auto_init_busy_flag_ff);

// [dv/tb.sv]
// Self-checking bench for the mode register file.
`timescale 1ns/1ns
module tb;
  import smr_pkg::*;
  localparam int INIT_N = 20;
  localparam int ZQ_N = 5;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic zq_sup = 1'b0;
  logic zq_gnd = 1'b0;
  logic wr_ap_done = 1'b0;
  logic [7:0] refresh_status = 8'h00;
  smr_cmd_t cmd;
  smr_burst_t burst;
  logic [7:0] rd_data, lat, drv, bank, seg, vend, zq_code, q, op;
  logic zq_busy, trim, busy, pre;
  // Read valid pulse and read strobe, compared after every read.
  logic rd_vld, rd_stb;
  logic [31:0] rng = 32'h83F4;
  int fails = 0;
  int n_tests = 0;
  // Bench model: writable registers, self-test code and busy flag.
  int m_reg [32];
  int m_zq, m_busy, m_stb, n;
  logic [7:0] idx_list [17] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
    8'h08, 8'h09, 8'h0A, 8'h10, 8'h11, 8'h20, 8'h28, 8'h0B, 8'h80};
  smr_ctrl_model u_smr_ctrl_model (.clk_sys(clk_sys), .rd_data_ff(rd_data), .cmd(cmd));
  smr_mode_regs #(.INIT_CYCLES(INIT_N), .ZQ_CYCLES(ZQ_N)) u_smr_mode_regs (.clk_sys(clk_sys),
    .reset(reset), .cmd(cmd), .zq_pin_tied_supply(zq_sup), .zq_pin_shorted_ground(zq_gnd),
    .refresh_status(refresh_status), .wr_ap_done(wr_ap_done), .rd_data_ff(rd_data),
    .rd_valid_ff(rd_vld), .rd_strobe_ff(rd_stb), .burst_cfg_ff(burst), .latency_cfg_ff(lat),
    .drive_cfg_ff(drv), .bank_mask_ff(bank), .seg_mask_ff(seg), .vend_test_ff(vend),
    .zq_code_ff(zq_code), .zq_busy_ff(zq_busy), .use_factory_trim_ff(trim),
    .auto_init_busy_flag_ff(busy), .internal_precharge_ff(pre));
  initial forever #5 clk_sys = ~clk_sys;
  function automatic logic [7:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng[7:0];
  endfunction
  // Read view of the model; write-only and reserved places answer zero.
  function automatic int mdl_rd(input logic [7:0] idx);
    case (idx)
      8'h00: return (m_zq << 3) | m_busy;
      8'h04: return refresh_status & SMR_REFRESH_MASK;
      8'h05: return 8'h5A;
      8'h06: return 8'h01;
      8'h07: return 8'h02;
      8'h08: return 8'h18;
      8'h20: return 8'h55;
      8'h28: return 8'hAA;
      default: return 0;
    endcase
  endfunction
  task automatic give_verdict();
    $display("Counts: %0d compares, %0d mismatches", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input int exp);
    n_tests++;
    if (got !== 8'(exp))
    begin
      $display("MISMATCH %0t got %h expected %h", $time, got, 8'(exp));
      fails++;
    end
  endtask
  task automatic defaults();
    foreach (m_reg[i]) m_reg[i] = 0;
    m_reg[1] = 8'h22;
    m_busy = 1;
  endtask
  task automatic chk_cfg();
    chk(burst, m_reg[1]);
    chk(lat, m_reg[2]);
    chk(drv, m_reg[3]);
    chk(vend, m_reg[9]);
    chk(bank, m_reg[16]);
    chk(seg, m_reg[17]);
  endtask
  task automatic rd(input logic [7:0] idx);
    u_smr_ctrl_model.issue(1'b1, idx, 8'h00, q);
    chk(q, mdl_rd(idx));
    // The strobe toggles once for every read, whatever the index.
    m_stb = 1 - m_stb;
    chk({7'h0, rd_vld}, 1);
    chk({7'h0, rd_stb}, m_stb);
  endtask
  // Register writes are refused by the model while busy, as the device does; reset writes are not.
  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    u_smr_ctrl_model.issue(1'b0, idx, v, q);
    v = v & ((idx == 8'h02 || idx == 8'h03) ? 8'h0F : 8'hFF);
    if (idx == 8'h3F)
      defaults();
    else if (m_busy == 0 && idx inside {8'h01, 8'h02, 8'h03, 8'h09, 8'h10, 8'h11})
      m_reg[idx] = (idx == 8'h01 && v[2:0] != SMR_BL_FOUR) ? (v & 8'hEF) : v;
    chk_cfg();
  endtask
  // Counts cycles while a busy flag stays high, within a bound.
  task automatic wait_cnt(input bit zq);
    n = 0;
    while ((zq ? zq_busy : busy) === 1'b1 && n < 1200)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (n >= 1200)
    begin
      $display("MISMATCH %0t busy wait timed out", $time);
      fails++;
      give_verdict();
    end
  endtask
  initial
  begin
    defaults();
    // Each pass takes a hardware reset, then one self-test outcome.
    for (int k = 0; k < 3; k++)
    begin
      reset = 1'b1;
      repeat (8) @(posedge clk_sys);
      #1;
      reset = 1'b0;
      defaults();
      m_zq = 0;
      m_stb = 0;
      rd(8'h00);
      wr(8'h01, 8'h4B);
      wait_cnt(1'b0);
      m_busy = 0;
      rd(8'h00);
      zq_gnd = (k == 1);
      zq_sup = (k == 2);
      op = rnd();
      wr(8'h0A, op);
      chk(zq_code, op);
      wait_cnt(1'b1);
      chk(8'(n), ZQ_N);
      m_zq = 3 - k;
      rd(8'h00);
      chk({7'h0, trim}, k > 0);
      $display("test selftest %0d done", k);
    end
    wr(8'h0A, 8'h33);
    chk({7'h0, zq_busy}, 0);
    chk(zq_code, op);
    for (int i = 0; i < 34; i++)
    begin
      op = rnd();
      if (idx_list[i % 17] == 8'h01)
        op = {3'(1 + op % 6), op[4:3], 3'(2 + op[2:0] % 3)};
      wr(idx_list[i % 17], op);
      if (idx_list[i % 17] == 8'h01)
      begin
        wr_ap_done = 1'b1;
        @(posedge clk_sys);
        #1;
        wr_ap_done = 1'b0;
        n = 0;
        while (pre !== 1'b1 && n < 20)
        begin
          @(posedge clk_sys);
          #1;
          n++;
        end
        chk(8'(n), op[7:5] + 2);
        if (n == 20) give_verdict();
      end
    end
    foreach (idx_list[i])
    begin
      refresh_status = rnd();
      rd(idx_list[i]);
    end
    $display("test access done");
    wr(8'h3F, rnd());
    chk({7'h0, busy}, 1);
    wait_cnt(1'b0);
    chk(8'(n), INIT_N);
    $display("test soft reset done");
    give_verdict();
  end
endmodule // tb

// [rtl/smr_mode_regs.sv]
// Mode register file of a low-power DDR SDRAM, read and written by mode register commands.
`timescale 1ns/1ns
module smr_mode_regs
  import smr_pkg::*;
#(
  // Auto-initialisation length in cycles after a reset write (hardware reset always uses SMR_INIT_CYC); shorten for simulation.
  parameter int INIT_CYCLES = SMR_INIT_CYC,
  // Calibration length in cycles.
  parameter int ZQ_CYCLES = SMR_ZQ_CYC,
  // Read-only identity contents; values are arbitrary.
  parameter logic [7:0] MAKER_VALUE = 8'h5A,
  parameter logic [7:0] REV_ONE_VALUE = 8'h01,
  parameter logic [7:0] REV_TWO_VALUE = 8'h02,
  parameter logic [7:0] GEOMETRY_VALUE = 8'h18,
  parameter logic [7:0] PATTERN_A_VALUE = 8'h55,
  parameter logic [7:0] PATTERN_B_VALUE = 8'hAA
)(
  input wire logic clk_sys,
  input wire logic reset,
  // Command from the controller, one cycle per command.
  input wire smr_cmd_t cmd,
  // Pad status sensed on the calibration pin.
  input wire logic zq_pin_tied_supply,
  input wire logic zq_pin_shorted_ground,
  // Device refresh status bits for the refresh-rate register.
  input wire logic [7:0] refresh_status,
  // Write burst with auto precharge has finished its data.
  input wire logic wr_ap_done,
  // Read answer.
  output logic [7:0] rd_data_ff,
  output logic rd_valid_ff,
  output logic rd_strobe_ff,
  // Decoded configuration, sequencer status flags and the internal precharge pulse.
  output smr_burst_t burst_cfg_ff,
  output logic [7:0] latency_cfg_ff,
  output logic [7:0] drive_cfg_ff,
  output logic [7:0] bank_mask_ff,
  output logic [7:0] seg_mask_ff,
  output logic [7:0] vend_test_ff,
  output logic [7:0] zq_code_ff,
  output logic zq_busy_ff,
  output logic use_factory_trim_ff,
  output logic auto_init_busy_flag_ff,
  output logic internal_precharge_ff
);

  // State of the auto-initialisation and calibration sequencer.
  typedef enum logic [1:0] {SMR_INIT, SMR_IDLE, SMR_ZQ} smr_state_t;
  smr_state_t state_ff;
  smr_state_t nxt_state;
  // Shared down counter for init and calibration.
  logic [SMR_CNT_W-1:0] cnt_ff;
  logic [SMR_CNT_W-1:0] nxt_cnt;
  // Self-test result field.
  logic [1:0] zq_selftest_result_ff;
  // Write-recovery countdown for auto precharge.
  logic [3:0] wr_cnt_ff;
  // Decoded strobes of the current command.
  logic wr_cmd;
  logic soft_rst;
  logic zq_start;

  // Write strobe, ungated; register writes and calibration start are ignored while auto-init runs, reset writes are not.
  assign wr_cmd = cmd.wr;
  // Reset write, operand ignored.
  // reset write decode
  assign soft_rst = wr_cmd && (cmd.register_index == SMR_IDX_SOFT_RST);
  // Calibration start; a bad self-test suppresses it so trim stays in use.
  // ignore calibration commands
  assign zq_start = wr_cmd && (cmd.register_index == SMR_IDX_ZQ_CAL) &&
                    (state_ff == SMR_IDLE) && !use_factory_trim_ff;

  // Sequencer next state: init countdown, then idle, calibration on request.
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    unique case (state_ff)
      SMR_INIT:
      begin
        if (cnt_ff == '0)
          nxt_state = SMR_IDLE;
        else
          nxt_cnt = cnt_ff - 1'b1;
      end
      SMR_IDLE:
      begin
        if (zq_start)
        begin
          nxt_state = SMR_ZQ;
          nxt_cnt = SMR_CNT_W'(ZQ_CYCLES - 1);
        end
      end
      SMR_ZQ:
      begin
        if (cnt_ff == '0)
          nxt_state = SMR_IDLE;
        else
          nxt_cnt = cnt_ff - 1'b1;
      end
    endcase
    // A reset write restarts auto-initialisation from any state.
    if (soft_rst)
    begin
      nxt_state = SMR_INIT;
      nxt_cnt = SMR_CNT_W'(INIT_CYCLES - 1);
    end
  end

  // Sequencer registers.
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      state_ff <= SMR_INIT;
      cnt_ff <= SMR_CNT_W'(SMR_INIT_CYC - 1);
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
    end
  end

  // Status outputs of the sequencer.
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      auto_init_busy_flag_ff <= 1'b1;
      zq_busy_ff <= 1'b0;
    end
    else
    begin
      auto_init_busy_flag_ff <= (nxt_state == SMR_INIT);
      zq_busy_ff <= (nxt_state == SMR_ZQ);
    end
  end

  // Self-test result, captured when calibration finishes.
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      zq_selftest_result_ff <= SMR_ZQ_NONE;
      use_factory_trim_ff <= 1'b0;
    end
    else if (soft_rst)
    begin
      zq_selftest_result_ff <= SMR_ZQ_NONE;
      use_factory_trim_ff <= 1'b0;
    end
    else if (state_ff == SMR_ZQ && cnt_ff == '0)
    begin
      if (zq_pin_tied_supply)
      begin
        zq_selftest_result_ff <= SMR_ZQ_SUPPLY_OPEN;
        use_factory_trim_ff <= 1'b1;
      end
      else if (zq_pin_shorted_ground)
      begin
        zq_selftest_result_ff <= SMR_ZQ_GROUND;
        use_factory_trim_ff <= 1'b1;
      end
      else
        zq_selftest_result_ff <= SMR_ZQ_GOOD;
    end
  end

  // Writable registers; read-only and reserved indices fall through untouched.
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      burst_cfg_ff <= smr_burst_t'(SMR_BURST_WR_RST);
      latency_cfg_ff <= SMR_ZERO_BYTE;
      drive_cfg_ff <= SMR_ZERO_BYTE;
      bank_mask_ff <= SMR_ZERO_BYTE;
      seg_mask_ff <= SMR_ZERO_BYTE;
      vend_test_ff <= SMR_ZERO_BYTE;
      zq_code_ff <= SMR_ZERO_BYTE;
    end
    else if (soft_rst)
    begin
      burst_cfg_ff <= smr_burst_t'(SMR_BURST_WR_RST);
      latency_cfg_ff <= SMR_ZERO_BYTE;
      drive_cfg_ff <= SMR_ZERO_BYTE;
      bank_mask_ff <= SMR_ZERO_BYTE;
      seg_mask_ff <= SMR_ZERO_BYTE;
      vend_test_ff <= SMR_ZERO_BYTE;
    end
    else if (wr_cmd && state_ff != SMR_INIT)
    begin
      unique case (cmd.register_index)
        SMR_IDX_BURST_WR:
        begin
          // no-wrap only with length four; otherwise force wrapping.
          burst_cfg_ff <= cmd.operand_bits;
          if (cmd.operand_bits[2:0] != SMR_BL_FOUR)
            burst_cfg_ff.wrap_select <= 1'b0;
        end
        SMR_IDX_LATENCY: latency_cfg_ff <= cmd.operand_bits;
        SMR_IDX_DRIVE: drive_cfg_ff <= cmd.operand_bits;
        SMR_IDX_VEND_TEST: vend_test_ff <= cmd.operand_bits;
        SMR_IDX_BANK_MASK: bank_mask_ff <= cmd.operand_bits;
        SMR_IDX_SEG_MASK: seg_mask_ff <= cmd.operand_bits;
        SMR_IDX_ZQ_CAL:
        begin
          if (zq_start)
            zq_code_ff <= cmd.operand_bits;
        end
        default:
        begin
          // Read-only and reserved indices: no effect.
        end
      endcase
    end
  end

  // Read answer with one cycle latency; strobe toggles on every read.
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      rd_data_ff <= SMR_ZERO_BYTE;
      rd_valid_ff <= 1'b0;
      rd_strobe_ff <= 1'b0;
    end
    else
    begin
      rd_valid_ff <= cmd.rd;
      if (cmd.rd)
        rd_strobe_ff <= ~rd_strobe_ff;
      if (cmd.rd)
      begin
        unique case (cmd.register_index)
          SMR_IDX_DEV_INFO:
          begin
            rd_data_ff <= SMR_ZERO_BYTE;
            rd_data_ff[SMR_DI_BUSY_BIT] <= auto_init_busy_flag_ff;
            rd_data_ff[SMR_DI_TYPE_BIT] <= SMR_DEV_TYPE_S4;
            rd_data_ff[SMR_DI_ZQ_MSB:SMR_DI_ZQ_LSB] <= zq_selftest_result_ff;
          end
          SMR_IDX_REFRESH: rd_data_ff <= refresh_status & SMR_REFRESH_MASK;
          SMR_IDX_MAKER: rd_data_ff <= MAKER_VALUE;
          SMR_IDX_REV_ONE: rd_data_ff <= REV_ONE_VALUE;
          SMR_IDX_REV_TWO: rd_data_ff <= REV_TWO_VALUE;
          SMR_IDX_GEOMETRY: rd_data_ff <= GEOMETRY_VALUE;
          SMR_IDX_PATTERN_A: rd_data_ff <= PATTERN_A_VALUE;
          SMR_IDX_PATTERN_B: rd_data_ff <= PATTERN_B_VALUE;
          default: rd_data_ff <= SMR_ZERO_BYTE;
        endcase
      end
    end
  end

  // Write-recovery countdown before the internal precharge pulse.
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      wr_cnt_ff <= '0;
      internal_precharge_ff <= 1'b0;
    end
    else
    begin
      internal_precharge_ff <= 1'b0;
      if (wr_ap_done)
        wr_cnt_ff <= {1'b0, burst_cfg_ff.write_recovery_count} + SMR_WR_OFFSET;
      else if (wr_cnt_ff != '0)
      begin
        wr_cnt_ff <= wr_cnt_ff - 1'b1;
        if (wr_cnt_ff == 4'h1)
          internal_precharge_ff <= 1'b1;
      end
    end
  end

endmodule // smr_mode_regs

// [rtl/smr_pkg.sv]
// Package with register map, field layout and timing constants of the mode register file.
package smr_pkg;
  // Register indices on the 8-bit register address.
  localparam logic [7:0] SMR_IDX_DEV_INFO = 8'h00;
  localparam logic [7:0] SMR_IDX_BURST_WR = 8'h01;
  localparam logic [7:0] SMR_IDX_LATENCY = 8'h02;
  localparam logic [7:0] SMR_IDX_DRIVE = 8'h03;
  localparam logic [7:0] SMR_IDX_REFRESH = 8'h04;
  localparam logic [7:0] SMR_IDX_MAKER = 8'h05;
  localparam logic [7:0] SMR_IDX_REV_ONE = 8'h06;
  localparam logic [7:0] SMR_IDX_REV_TWO = 8'h07;
  localparam logic [7:0] SMR_IDX_GEOMETRY = 8'h08;
  localparam logic [7:0] SMR_IDX_VEND_TEST = 8'h09;
  localparam logic [7:0] SMR_IDX_ZQ_CAL = 8'h0A;
  localparam logic [7:0] SMR_IDX_BANK_MASK = 8'h10;
  localparam logic [7:0] SMR_IDX_SEG_MASK = 8'h11;
  localparam logic [7:0] SMR_IDX_PATTERN_A = 8'h20;
  localparam logic [7:0] SMR_IDX_PATTERN_B = 8'h28;
  localparam logic [7:0] SMR_IDX_SOFT_RST = 8'h3F;
  // Field positions in the device information register.
  localparam int SMR_DI_BUSY_BIT = 0;
  localparam int SMR_DI_TYPE_BIT = 1;
  localparam int SMR_DI_ZQ_LSB = 3;
  localparam int SMR_DI_ZQ_MSB = 4;
  // Device type value for this class of part.
  localparam logic SMR_DEV_TYPE_S4 = 1'h0;
  // Self-test result codes.
  localparam logic [1:0] SMR_ZQ_NONE = 2'h0;
  localparam logic [1:0] SMR_ZQ_SUPPLY_OPEN = 2'h1;
  localparam logic [1:0] SMR_ZQ_GROUND = 2'h2;
  localparam logic [1:0] SMR_ZQ_GOOD = 2'h3;
  // Reset values of the writable configuration registers.
  localparam logic [7:0] SMR_BURST_WR_RST = 8'h22;
  localparam logic [7:0] SMR_ZERO_BYTE = 8'h00;
  // Burst length codes.
  localparam logic [2:0] SMR_BL_FOUR = 3'h2;
  // Refresh-rate register keeps only the temperature flag and rate field; the rest reads zero.
  localparam logic [7:0] SMR_REFRESH_MASK = 8'h87;
  // Timing: auto initialisation and calibration durations.
  localparam int SMR_CLK_NS = 10;
  localparam int SMR_INIT_NS = 10000;
  localparam int SMR_ZQ_NS = 1000;
  localparam int SMR_INIT_CYC = SMR_INIT_NS / SMR_CLK_NS;
  localparam int SMR_ZQ_CYC = (SMR_ZQ_NS + SMR_CLK_NS - 1) / SMR_CLK_NS;
  localparam int SMR_CNT_W = 16;
  // Write-recovery code offset: code 1 means 3 cycles.
  localparam logic [3:0] SMR_WR_OFFSET = 4'h2;

  // Command from the controller.
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] register_index;
    logic [7:0] operand_bits;
  } smr_cmd_t;

  // Decoded burst and write configuration.
  typedef struct packed {
    logic [2:0] write_recovery_count;
    logic wrap_select;
    logic burst_order_type;
    logic [2:0] burst_length_field;
  } smr_burst_t;
endpackage
